// ==== core/hpm_device.sv ====
`timescale 1ns/100ps
module hpm_device
    import hpm_pkg::*;
(
    input  wire logic                  core_clk,
    input  wire logic                  rst,
    hpm_if.device                      hp,
    input  wire hpm_pkg::hpm_mode_t    mode_sel,
    input  wire logic                  pseudo16_en,
    input  wire logic                  multiword_en,
    input  wire logic                  irq_trigger_wr,
    input  wire logic                  status_pending,
    input  wire logic                  data_pending,
    input  wire logic                  last_byte,
    input  wire logic [HPM_DATA_W-1:0] tx_word,
    output logic [HPM_DATA_W-1:0]      rx_word,
    output logic                       rx_valid,
    output logic                       rx_is_cmd,
    output logic                       tx_taken,
    output logic                       door_switch,
    output logic                       subcpu_reset_n
);
    import hpm_pkg::*;

    // ==========================================================
    // access decode
    logic rd_q;
    logic wr_q;
    logic next_rd_q;
    logic next_wr_q;
    logic rd_rise;
    logic wr_rise;
    logic sel_ok;
    logic dma_xfer;
    logic [1:0] stretch;
    logic [1:0] next_stretch;
    logic host_irq;
    logic next_host_irq;
    logic dreq;
    logic next_dreq;
    logic mw_started;
    logic next_mw_started;
    logic first_byte;
    logic next_first_byte;
    logic [HPM_BYTE_W-1:0] byte_hold;
    logic [HPM_BYTE_W-1:0] next_byte_hold;
    logic next_door;
    logic next_scr;

    logic legacy;
    assign legacy  = (mode_sel != HPM_MODE_PACKET);
    assign rd_rise = !hp.rd_n && !rd_q;
    assign wr_rise = !hp.wr_n && !wr_q;
    assign sel_ok  = legacy ? !hp.cs1_n : (!hp.cs1_n || hp.cs2);
    assign dma_xfer = legacy ? !hp.cs2 : !hp.dmack_n;

    always_comb begin
        next_rd_q       = !hp.rd_n;
        next_wr_q       = !hp.wr_n;
        next_stretch    = (stretch != 2'h0) ? stretch - 2'h1 : 2'h0;
        next_host_irq   = host_irq;
        next_dreq       = dreq;
        next_mw_started = mw_started;
        next_first_byte = first_byte;
        next_byte_hold  = byte_hold;
        next_door       = door_switch;
        next_scr        = 1'b1;
        if ((rd_rise || wr_rise) && sel_ok && !dma_xfer) begin
            next_stretch = 2'(HPM_STRETCH_CYC);
        end
        if (mode_sel == HPM_MODE_PACKET && sel_ok && !hp.cs1_n
                && hp.addr == HPM_ADDR_STATUS && (rd_rise || wr_rise))
            next_host_irq = 1'b0;
        if (mode_sel == HPM_MODE_PACKET && irq_trigger_wr)
            next_host_irq = 1'b1;
        if (mode_sel != HPM_MODE_LEGACY1 && wr_rise && sel_ok
                && hp.addr == HPM_ADDR_CMD
                && hp.host_data_out[7:0] == HPM_RESET_CMD)
            next_scr = 1'b0;
        if (!multiword_en || mode_sel == HPM_MODE_LEGACY2) begin
            next_dreq = data_pending && hp.dmack_n;
        end else begin
            if (data_pending && !mw_started) begin
                next_dreq       = 1'b1;
                next_mw_started = 1'b1;
            end
            if (!hp.dmack_n)
                next_dreq = 1'b0;
            if (!data_pending)
                next_mw_started = 1'b0;
        end
        if (mode_sel == HPM_MODE_LEGACY2 && pseudo16_en
                && !hp.dmack_n && rd_rise) begin
            next_first_byte = !first_byte;
            next_byte_hold  = tx_word[15:8];
        end
        if (mode_sel != HPM_MODE_LEGACY2 || !pseudo16_en)
            next_first_byte = 1'b0;
        if (mode_sel == HPM_MODE_LEGACY2)
            next_door = hp.addr[2];
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rd_q           <= 1'b0;
            wr_q           <= 1'b0;
            stretch        <= 2'h0;
            host_irq       <= 1'b0;
            dreq           <= 1'b0;
            mw_started     <= 1'b0;
            first_byte     <= 1'b0;
            byte_hold      <= 8'h00;
            door_switch    <= 1'b0;
            subcpu_reset_n <= 1'b1;
        end else begin
            rd_q           <= next_rd_q;
            wr_q           <= next_wr_q;
            stretch        <= next_stretch;
            host_irq       <= next_host_irq;
            dreq           <= next_dreq;
            mw_started     <= next_mw_started;
            first_byte     <= next_first_byte;
            byte_hold      <= next_byte_hold;
            door_switch    <= next_door;
            subcpu_reset_n <= next_scr;
        end
    end

    // ==========================================================
    // pin function mux
    logic [HPM_DATA_W-1:0] n_dout;
    logic n_doe;
    logic n_p46;
    logic n_p46oe;
    logic n_p47;
    logic n_p48;
    logic n_p49;
    logic n_io16;
    logic [HPM_DATA_W-1:0] n_rx;
    logic n_rxv;
    logic n_cmd;
    logic n_tk;

    always_comb begin
        n_dout  = tx_word;
        n_doe   = !hp.rd_n && (sel_ok || !hp.dmack_n);
        n_p46   = 1'b1;
        n_p46oe = 1'b0;
        n_p47   = 1'b1;
        n_p48   = 1'b0;
        n_p49   = 1'b0;
        n_io16  = 1'b0;
        n_rx    = hp.host_data_out;
        n_rxv   = wr_rise && (sel_ok || !hp.dmack_n);
        n_cmd   = 1'b0;
        n_tk    = rd_rise && (sel_ok || !hp.dmack_n);
        case (mode_sel)
            HPM_MODE_PACKET: begin
                n_p46oe = (next_stretch != 2'h0);
                n_p46   = 1'b0;
                n_p47   = subcpu_reset_n && next_scr;
                n_p48   = next_dreq;
                n_p49   = next_host_irq;
                n_io16  = !hp.cs1_n && hp.addr == HPM_ADDR_DATA
                          && hp.dmack_n;
            end
            HPM_MODE_LEGACY1: begin
                n_p46oe = 1'b1;
                n_p46   = hp.cs2 ? !(next_stretch != 2'h0)
                                 : !data_pending;
                n_p47   = !status_pending;
                n_p48   = !data_pending;
                n_p49   = !(last_byte && (rd_rise || wr_rise));
            end
            HPM_MODE_LEGACY2: begin
                n_p46oe = 1'b1;
                n_p46   = pseudo16_en && next_first_byte;
                n_p47   = subcpu_reset_n && next_scr;
                n_p48   = next_dreq;
                n_p49   = next_first_byte;
            end
            default: begin
                n_p46oe = 1'b0;
            end
        endcase
        if (legacy) begin
            n_dout = {8'h00, first_byte ? byte_hold : tx_word[7:0]};
            n_rx   = {8'h00, hp.host_data_out[7:0]};
            // address bit 0 as command select
            n_cmd  = hp.addr[0];
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            hp.dev_data_out <= HPM_RESET_XFER;
            hp.dev_data_oe  <= 1'b0;
            hp.pin46_out    <= 1'b1;
            hp.pin46_oe     <= 1'b0;
            hp.pin47        <= 1'b1;
            hp.pin48        <= 1'b0;
            hp.pin49        <= 1'b0;
            hp.iocs16_out   <= 1'b0;
            hp.iocs16_oe    <= 1'b0;
            rx_word         <= HPM_RESET_XFER;
            rx_valid        <= 1'b0;
            rx_is_cmd       <= 1'b0;
            tx_taken        <= 1'b0;
        end else begin
            hp.dev_data_out <= n_dout;
            hp.dev_data_oe  <= n_doe;
            hp.pin46_out    <= n_p46;
            hp.pin46_oe     <= n_p46oe;
            hp.pin47        <= n_p47;
            hp.pin48        <= n_p48;
            hp.pin49        <= n_p49;
            // open collector: pulls low when active
            hp.iocs16_out   <= 1'b0;
            hp.iocs16_oe    <= n_io16;
            rx_word         <= n_rx;
            rx_valid        <= n_rxv;
            rx_is_cmd       <= n_cmd;
            tx_taken        <= n_tk;
        end
    end
endmodule

// ==== shared/hpm_pkg.sv ====
package hpm_pkg;
    // host port modes selected by the sub-processor
    typedef enum logic [1:0] {
        HPM_MODE_PACKET  = 2'h0,
        HPM_MODE_LEGACY1 = 2'h1,
        HPM_MODE_LEGACY2 = 2'h2
    } hpm_mode_t;

    localparam int HPM_DATA_W   = 16;
    localparam int HPM_BYTE_W   = 8;
    localparam int HPM_ADDR_W   = 3;
    // packet-interface register addresses (cs1 region, da)
    localparam logic [2:0] HPM_ADDR_DATA   = 3'h0;
    localparam logic [2:0] HPM_ADDR_STATUS = 3'h7;
    localparam logic [2:0] HPM_ADDR_CMD    = 3'h7;
    localparam logic [2:0] HPM_ADDR_RESET  = 3'h6;
    // wait-stretch length in core clocks for a pio access
    localparam int HPM_STRETCH_CYC = 2;
    localparam logic [7:0] HPM_RESET_CMD   = 8'h08;
    localparam logic [15:0] HPM_RESET_XFER = 16'h0000;
endpackage

// ==== shared/hpm_if.sv ====
`timescale 1ns/100ps
interface hpm_if;
    import hpm_pkg::*;
    logic                  cs1_n;
    logic                  cs2;
    logic [HPM_ADDR_W-1:0] addr;
    logic                  wr_n;
    logic                  rd_n;
    logic                  dmack_n;
    logic [HPM_DATA_W-1:0] host_data_out;
    logic                  host_data_oe;
    logic [HPM_DATA_W-1:0] dev_data_out;
    logic                  dev_data_oe;
    logic                  pin46_out;
    logic                  pin46_oe;
    logic                  pin47;
    logic                  pin48;
    logic                  pin49;
    logic                  iocs16_out;
    logic                  iocs16_oe;

    modport device (
        input  cs1_n, cs2, addr, wr_n, rd_n, dmack_n,
        input  host_data_out, host_data_oe,
        output dev_data_out, dev_data_oe, pin46_out, pin46_oe,
        output pin47, pin48, pin49, iocs16_out, iocs16_oe
    );
    modport host (
        output cs1_n, cs2, addr, wr_n, rd_n, dmack_n,
        output host_data_out, host_data_oe,
        input  dev_data_out, dev_data_oe, pin46_out, pin46_oe,
        input  pin47, pin48, pin49, iocs16_out, iocs16_oe
    );
endinterface

// ==== core/hpm_host.sv ====
`timescale 1ns/100ps
module hpm_host
    import hpm_pkg::*;
(
    input  wire logic                  core_clk,
    input  wire logic                  rst,
    hpm_if.host                        hp,
    input  wire hpm_pkg::hpm_mode_t    mode_sel,
    input  wire logic                  req_valid,
    input  wire logic                  req_write,
    input  wire logic                  req_dma,
    input  wire logic [HPM_ADDR_W-1:0] req_addr,
    input  wire logic [HPM_DATA_W-1:0] req_data,
    output logic                       req_ready,
    output logic [HPM_DATA_W-1:0]      rsp_data,
    output logic                       rsp_valid
);
    import hpm_pkg::*;

    // ==========================================================
    // access sequencer
    typedef enum logic [1:0] {
        HPM_IDLE, HPM_STROBE, HPM_SETTLE, HPM_HOLD
    } hpm_hst_t;
    hpm_hst_t state;
    hpm_hst_t next_state;
    logic next_cs1;
    logic next_cs2;
    logic [HPM_ADDR_W-1:0] next_addr;
    logic next_wr;
    logic next_rd;
    logic next_ack;
    logic [HPM_DATA_W-1:0] next_hdo;
    logic next_hoe;
    logic next_ready;
    logic [HPM_DATA_W-1:0] next_rsp;
    logic next_rspv;
    logic waiting;
    logic legacy;
    logic first_latched;

    assign legacy = (mode_sel != HPM_MODE_PACKET);
    // in the second legacy mode pin 46 is the latch, never a wait
    assign waiting = (hp.pin46_oe && !hp.pin46_out
                      && (mode_sel == HPM_MODE_PACKET
                          || (mode_sel == HPM_MODE_LEGACY1 && hp.cs2)));
    // hold off pio during first byte
    assign first_latched = (mode_sel == HPM_MODE_LEGACY2) && hp.pin49;

    always_comb begin
        next_state = state;
        next_cs1   = hp.cs1_n;
        next_cs2   = hp.cs2;
        next_addr  = hp.addr;
        next_wr    = hp.wr_n;
        next_rd    = hp.rd_n;
        next_ack   = hp.dmack_n;
        next_hdo   = hp.host_data_out;
        next_hoe   = hp.host_data_oe;
        next_ready = 1'b0;
        next_rsp   = rsp_data;
        next_rspv  = 1'b0;
        case (state)
            HPM_IDLE: begin
                next_ready = !(first_latched && !req_dma);
                if (req_valid && req_ready) begin
                    next_cs1  = !(legacy || !req_dma);
                    next_cs2  = legacy ? !req_dma : 1'b0;
                    next_addr = req_addr;
                    next_hdo  = req_data;
                    next_hoe  = req_write;
                    next_ready = 1'b0;
                    next_state = HPM_STROBE;
                end
            end
            HPM_STROBE: begin
                if (req_dma && mode_sel != HPM_MODE_LEGACY1 && hp.pin48)
                    next_ack = 1'b0;
                if (!req_dma || !next_ack || mode_sel == HPM_MODE_LEGACY1) begin
                    next_wr    = !next_hoe;
                    next_rd    = next_hoe;
                    next_state = HPM_SETTLE;
                end
            end
            // wait answer lands one cycle after the strobe is seen
            HPM_SETTLE: next_state = HPM_HOLD;
            HPM_HOLD: begin
                if (!waiting) begin
                    next_rsp   = hp.dev_data_out;
                    next_rspv  = hp.rd_n == 1'b0;
                    next_wr    = 1'b1;
                    next_rd    = 1'b1;
                    next_ack   = 1'b1;
                    next_cs1   = 1'b1;
                    next_cs2   = 1'b0;
                    next_hoe   = 1'b0;
                    next_state = HPM_IDLE;
                end
            end
            default: next_state = HPM_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state            <= HPM_IDLE;
            hp.cs1_n         <= 1'b1;
            hp.cs2           <= 1'b0;
            hp.addr          <= 3'h0;
            hp.wr_n          <= 1'b1;
            hp.rd_n          <= 1'b1;
            hp.dmack_n       <= 1'b1;
            hp.host_data_out <= HPM_RESET_XFER;
            hp.host_data_oe  <= 1'b0;
            req_ready        <= 1'b0;
            rsp_data         <= HPM_RESET_XFER;
            rsp_valid        <= 1'b0;
        end else begin
            state            <= next_state;
            hp.cs1_n         <= next_cs1;
            hp.cs2           <= next_cs2;
            hp.addr          <= next_addr;
            hp.wr_n          <= next_wr;
            hp.rd_n          <= next_rd;
            hp.dmack_n       <= next_ack;
            hp.host_data_out <= next_hdo;
            hp.host_data_oe  <= next_hoe;
            req_ready        <= next_ready;
            rsp_data         <= next_rsp;
            rsp_valid        <= next_rspv;
        end
    end
endmodule

// ==== testbench/hpm_chk.sv ====
`timescale 1ns/100ps
// ================================================================
// pin-level checker on the joined host port
module hpm_chk
    import hpm_pkg::*;
(
    input wire logic               core_clk,
    input wire logic               rst,
    input wire hpm_pkg::hpm_mode_t mode_sel,
    input wire logic               pseudo16_en,
    input wire logic               irq_trigger_wr,
    input wire logic               cs2,
    input wire logic               rd_n,
    input wire logic               wr_n,
    input wire logic               dmack_n,
    input wire logic               pin46_out,
    input wire logic               pin46_oe,
    input wire logic               pin49,
    input wire logic               iocs16_out,
    input wire logic               iocs16_oe
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);

    chk_iordy_only_low: assert property (
        (mode_sel == HPM_MODE_PACKET && $past(mode_sel) == HPM_MODE_PACKET
         && pin46_oe) |-> !pin46_out)
        else $error("iordy driven high");
    chk_stretch_two_cyc: assert property (
        (mode_sel == HPM_MODE_PACKET && $rose(pin46_oe))
        |-> pin46_oe ##1 pin46_oe ##1 !pin46_oe)
        else $error("stretch length wrong");
    chk_wait_low_pio: assert property (
        (mode_sel == HPM_MODE_LEGACY1 && cs2
         && ($fell(rd_n) || $fell(wr_n)))
        |-> ##1 !pin46_out ##1 !pin46_out)
        else $error("wait pin not low during pio");
    // legacy2 with pseudo16 off for two cycles
    chk_latch_p16_only: assert property (
        (mode_sel == HPM_MODE_LEGACY2 && $past(mode_sel) == HPM_MODE_LEGACY2
         && !pseudo16_en && !$past(pseudo16_en))
        |-> !(pin46_oe && pin46_out))
        else $error("latch high outside pseudo16");
    chk_fbc_p16_only: assert property (
        (mode_sel == HPM_MODE_LEGACY2 && $past(mode_sel) == HPM_MODE_LEGACY2
         && !pseudo16_en && !$past(pseudo16_en)) |-> !pin49)
        else $error("first byte cycle outside pseudo16");
    chk_irq_on_trigger: assert property (
        (mode_sel == HPM_MODE_PACKET && $past(mode_sel) == HPM_MODE_PACKET
         && irq_trigger_wr) |-> ##[1:2] pin49)
        else $error("irq missing after trigger");
    chk_iocs16_packet: assert property (
        iocs16_oe |-> !iocs16_out && $past(mode_sel) == HPM_MODE_PACKET)
        else $error("iocs16 outside packet mode");
    chk_iocs16_no_dma: assert property (
        iocs16_oe |-> dmack_n && $past(dmack_n))
        else $error("iocs16 during dma");

    cover property ($rose(pin46_oe));
    cover property (irq_trigger_wr ##[1:2] pin49);
    cover property (iocs16_oe);
    cover property (mode_sel == HPM_MODE_LEGACY2 && $rose(pin46_out));
endmodule

// ==== testbench/test_cdrom_host_port_modes.sv ====
`timescale 1ns/100ps
module test_cdrom_host_port_modes;
    import hpm_pkg::*;
    logic                  core_clk = 1'b0;
    logic                  rst = 1'b1;
    hpm_mode_t             mode_sel;
    logic                  pseudo16_en, multiword_en, irq_trigger_wr;
    logic                  status_pending, data_pending, last_byte;
    logic                  req_valid, req_write, req_dma, req_ready;
    logic                  rx_valid, rx_is_cmd, tx_taken, door_switch;
    logic                  subcpu_reset_n, rsp_valid, rxc, p48d;
    logic [HPM_ADDR_W-1:0] req_addr;
    logic [HPM_DATA_W-1:0] tx_word, req_data, rx_word, rsp_data, rd, rxw;
    logic                  s46, s46h, s47, s48h, s49h, s49l, sio, sdoor, stk;
    int                    err_total = 0;
    int                    tests_run = 0;
    int                    cyc = 0;
    int                    r48;

    hpm_if hpm_if_inst ();
    hpm_device hpm_device_inst (.core_clk(core_clk), .rst(rst),
        .hp(hpm_if_inst.device), .mode_sel(mode_sel),
        .pseudo16_en(pseudo16_en), .multiword_en(multiword_en),
        .irq_trigger_wr(irq_trigger_wr), .status_pending(status_pending),
        .data_pending(data_pending), .last_byte(last_byte),
        .tx_word(tx_word), .rx_word(rx_word), .rx_valid(rx_valid),
        .rx_is_cmd(rx_is_cmd), .tx_taken(tx_taken),
        .door_switch(door_switch), .subcpu_reset_n(subcpu_reset_n));
    hpm_host hpm_host_inst (.core_clk(core_clk), .rst(rst),
        .hp(hpm_if_inst.host), .mode_sel(mode_sel), .req_valid(req_valid),
        .req_write(req_write), .req_dma(req_dma), .req_addr(req_addr),
        .req_data(req_data), .req_ready(req_ready), .rsp_data(rsp_data),
        .rsp_valid(rsp_valid));
    hpm_chk hpm_chk_inst (.core_clk(core_clk), .rst(rst),
        .mode_sel(mode_sel), .pseudo16_en(pseudo16_en),
        .irq_trigger_wr(irq_trigger_wr), .cs2(hpm_if_inst.cs2),
        .rd_n(hpm_if_inst.rd_n), .wr_n(hpm_if_inst.wr_n),
        .dmack_n(hpm_if_inst.dmack_n), .pin46_out(hpm_if_inst.pin46_out),
        .pin46_oe(hpm_if_inst.pin46_oe), .pin49(hpm_if_inst.pin49),
        .iocs16_out(hpm_if_inst.iocs16_out),
        .iocs16_oe(hpm_if_inst.iocs16_oe));

    always #4 core_clk = ~core_clk;

    // ================================================================
    // sticky pin monitor, sampled at the edge before updates land
    always @(posedge core_clk) begin
        s46 |= hpm_if_inst.pin46_oe & ~hpm_if_inst.pin46_out;
        s46h |= hpm_if_inst.pin46_oe & hpm_if_inst.pin46_out;
        s47 |= ~hpm_if_inst.pin47 | ~subcpu_reset_n;
        s48h |= hpm_if_inst.pin48;
        s49h |= hpm_if_inst.pin49;
        s49l |= ~hpm_if_inst.pin49;
        sio |= hpm_if_inst.iocs16_oe;
        sdoor |= door_switch;
        stk |= tx_taken;
        if (hpm_if_inst.pin48 && !p48d) r48++;
        p48d = hpm_if_inst.pin48;
        if (rx_valid) begin
            rxw = rx_word;
            rxc = rx_is_cmd;
        end
        cyc++;
        // whole run needs a few hundred cycles
        if (cyc == 20000) begin
            err_total++;
            results();
        end
    end

    task automatic clr;
        {s46, s46h, s47, s48h, s49h, s49l, sio, sdoor, stk} = '0;
        r48 = 0;
        p48d = 1'b1;
    endtask

    task automatic chk(input logic [15:0] e, input logic [15:0] g);
        tests_run++;
        if (g !== e) begin
            err_total++;
            $display("wrong value at %0t ns: exp %h got %h", $time, e, g);
        end
    endtask

    // one host access; request held until accepted, read answer on rsp_valid
    task automatic acc(input logic w, input logic dm,
                       input logic [2:0] a, input logic [15:0] dat);
        int n;
        req_write = w;
        req_dma = dm;
        req_addr = a;
        req_data = dat;
        req_valid = 1'b1;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (!req_ready && n < 50);
        #1 req_valid = 1'b0;
        n = 0;
        // writes give no response pulse: the return of ready ends them
        do begin
            @(posedge core_clk);
            n++;
        end while (!(w ? req_ready : rsp_valid) && n < 50);
        rd = rsp_data;
        if (n == 50) chk(16'h0, 16'hDEAD);
        repeat (3) @(posedge core_clk);
        #1;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    task automatic results;
        if (err_total == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // ================================================================
    initial begin
        {pseudo16_en, multiword_en, irq_trigger_wr, req_valid} = '0;
        {status_pending, data_pending, last_byte, req_write, req_dma} = '0;
        mode_sel = HPM_MODE_PACKET;
        tx_word = 16'h1234;
        req_addr = '0;
        req_data = '0;
        clr();
        tick(16);
        rst = 1'b0;
        tick(1);
        clr();
        acc(1'b1, 1'b0, HPM_ADDR_DATA, 16'hBEEF);
        chk(16'hBEEF, rxw);
        acc(1'b0, 1'b0, HPM_ADDR_DATA, 16'h0);
        chk(16'h1234, rd);
        chk(16'h1, 16'(sio));
        chk(16'h1, 16'(s46));
        chk(16'h1, 16'(stk));
        clr();
        // a request per word, plus one for the word still pending
        data_pending = 1'b1;
        acc(1'b0, 1'b1, HPM_ADDR_DATA, 16'h0);
        acc(1'b0, 1'b1, HPM_ADDR_DATA, 16'h0);
        chk(16'h0, 16'(sio));
        chk(16'h3, 16'(r48));
        // multi-word: one request for the whole transfer
        data_pending = 1'b0;
        tick(2);
        multiword_en = 1'b1;
        clr();
        data_pending = 1'b1;
        acc(1'b0, 1'b1, HPM_ADDR_DATA, 16'h0);
        chk(16'h1, 16'(r48));
        {multiword_en, data_pending} = '0;
        irq_trigger_wr = 1'b1;
        tick(1);
        irq_trigger_wr = 1'b0;
        tick(2);
        chk(16'h1, 16'(hpm_if_inst.pin49));
        acc(1'b0, 1'b0, HPM_ADDR_STATUS, 16'h0);
        chk(16'h0, 16'(hpm_if_inst.pin49));
        irq_trigger_wr = 1'b1;
        tick(1);
        irq_trigger_wr = 1'b0;
        tick(2);
        acc(1'b1, 1'b0, HPM_ADDR_CMD, 16'h00A0);
        chk(16'h0, 16'(hpm_if_inst.pin49));
        for (int i = 0; i < 2; i++) begin
            mode_sel = i ? HPM_MODE_LEGACY2 : HPM_MODE_PACKET;
            clr();
            acc(1'b1, 1'b0, HPM_ADDR_CMD, {8'h00, HPM_RESET_CMD});
            chk(16'h1, 16'(s47));
        end
        // legacy1: mode switch moves pin functions on the next core clock
        mode_sel = HPM_MODE_LEGACY1;
        status_pending = 1'b1;
        data_pending = 1'b1;
        tick(3);
        chk(16'h0, 16'(hpm_if_inst.pin47));
        chk(16'h0, 16'(hpm_if_inst.pin48));
        status_pending = 1'b0;
        data_pending = 1'b0;
        tick(3);
        chk(16'h1, 16'(hpm_if_inst.pin47));
        chk(16'h1, 16'(hpm_if_inst.pin48));
        clr();
        acc(1'b1, 1'b0, 3'h1, 16'hA55A);
        chk(16'h005A, rxw);
        chk(16'h1, 16'(rxc));
        chk(16'h1, 16'(s46));
        acc(1'b1, 1'b0, 3'h0, 16'h00C3);
        chk(16'h0, 16'(rxc));
        last_byte = 1'b1;
        clr();
        acc(1'b0, 1'b1, 3'h0, 16'h0);
        chk(16'h1, 16'(s49l));
        last_byte = 1'b0;
        // legacy2 pseudo16 dma read: high byte follows on next read
        mode_sel = HPM_MODE_LEGACY2;
        pseudo16_en = 1'b1;
        data_pending = 1'b1;
        tx_word = 16'h5AA5;
        clr();
        acc(1'b0, 1'b1, 3'h0, 16'h0);
        chk(16'h00A5, {8'h00, rd[7:0]});
        chk(16'h1, 16'(s49h));
        chk(16'h1, 16'(s46h));
        acc(1'b0, 1'b1, 3'h0, 16'h0);
        chk(16'h005A, {8'h00, rd[7:0]});
        pseudo16_en = 1'b0;
        clr();
        acc(1'b0, 1'b0, 3'h4, 16'h0);
        chk(16'h1, 16'(sdoor));
        chk(16'h0, 16'(s46h));
        results();
    end
endmodule
